// ---- hw/dect_top.sv ----
// dual event counter timer: apb registers, source routing, interrupt
// Overview of operation
// - two independent counters exist and a select register picks which one later accesses reach.
// - a counter adds one for each qualified occurrence of its increment source.
// - increment sources: tick, lines, user or logic outputs, unit pulses, exposure, frame wait.
// - increment source is qualified as level low, level high, falling, rising or any edge.
// - the begin pulse fires when the count reaches the delay count.
// - the finish pulse fires when the count reaches the duration count.
// - start trigger and clear sources are exclusive; selecting one turns the other off.
// - a counter starts counting when its start trigger source occurs.
// - the start trigger source is qualified with the same five activation modes.
// - the clear source resets the count when it occurs.
// - the clear source is qualified with the same five activation modes.
// - the present count is readable at any time.
// - on each clear the count just before it is captured and readable.
// - each counter's state is readable through a read-only register.
`timescale 1ns/1ps
`default_nettype none
module dect_top
    import dect_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources
    input wire logic microsecond_tick,
    input wire logic [NUM_LINES-1:0] line_in,
    input wire logic [3:0] soft_output_line,
    input wire logic [1:0] logic_unit_output,
    input wire logic exposure_begin_event,
    input wire logic exposure_finish_event,
    input wire logic frame_trigger_pending,
    // unit events and interrupt
    output logic [NUM_UNITS-1:0] unit_begin_pulse,
    output logic [NUM_UNITS-1:0] unit_finish_pulse,
    output logic irq
);
    logic unit_select_r;
    dect_cfg_t cfg_r [NUM_UNITS];
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [NUM_LINES-1:0] line_s;
    logic [NUM_SRC-1:0] src_cur;
    logic [NUM_SRC-1:0] src_prev_r;
    logic [CNT_W-1:0] count [NUM_UNITS];
    logic [CNT_W-1:0] captured [NUM_UNITS];
    dect_state_t state [NUM_UNITS];
    logic [NUM_UNITS-1:0] begin_p;
    logic [NUM_UNITS-1:0] finish_p;
    logic [NUM_UNITS-1:0] ovf_p;
    logic [NUM_UNITS-1:0] cap_wr;
    logic setup;
    logic wr_go;
    logic known;
    logic [IRQ_W-1:0] irq_events;
    logic [31:0] rd_mux;
    dect_sel_t wsel;

    dect_line_sync #(.WIDTH(NUM_LINES)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(line_in),
        .sync_out(line_s)
    );

    assign src_cur = {frame_trigger_pending, exposure_finish_event, exposure_begin_event,
                      logic_unit_output, finish_p, begin_p, soft_output_line, line_s,
                      microsecond_tick, 1'b0};

    // previous sample feeds the edge modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_r <= '0;
        end else begin
            src_prev_r <= src_cur;
        end
    end

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            dect_unit u_unit (
                .pclk(pclk),
                .presetn(presetn),
                .cfg(cfg_r[u]),
                .src_cur(src_cur),
                .src_prev(src_prev_r),
                .cap_wr(cap_wr[u]),
                .cap_wdata(pwdata),
                .count_r(count[u]),
                .captured_r(captured[u]),
                .state_r(state[u]),
                .begin_pulse_r(begin_p[u]),
                .finish_pulse_r(finish_p[u]),
                .overflow_pulse_r(ovf_p[u])
            );
            assign cap_wr[u] = wr_go && paddr == OFS_CAPTURED && unit_select_r == 1'(u);
        end
    endgenerate

    assign unit_begin_pulse = begin_p;
    assign unit_finish_pulse = finish_p;

    // registers answer with one wait-free access phase
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready_r && pwrite && !pslverr_r;
    assign wsel = '{act: pwdata[SEL_ACT_LSB +: ACT_W], src: pwdata[SEL_SRC_LSB +: SRC_W]};

    always_comb begin
        known = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_UNIT_SELECT: rd_mux[0] = unit_select_r;
            OFS_CONTROL: rd_mux[0] = cfg_r[unit_select_r].enable;
            OFS_INCREMENT: begin
                rd_mux[SEL_SRC_LSB +: SRC_W] = cfg_r[unit_select_r].inc.src;
                rd_mux[SEL_ACT_LSB +: ACT_W] = cfg_r[unit_select_r].inc.act;
            end
            OFS_START_TRIGGER: begin
                rd_mux[SEL_SRC_LSB +: SRC_W] = cfg_r[unit_select_r].trg.src;
                rd_mux[SEL_ACT_LSB +: ACT_W] = cfg_r[unit_select_r].trg.act;
            end
            OFS_CLEAR: begin
                rd_mux[SEL_SRC_LSB +: SRC_W] = cfg_r[unit_select_r].clr.src;
                rd_mux[SEL_ACT_LSB +: ACT_W] = cfg_r[unit_select_r].clr.act;
            end
            OFS_DELAY: rd_mux = cfg_r[unit_select_r].delay;
            OFS_DURATION: rd_mux = cfg_r[unit_select_r].duration;
            OFS_PRESENT_COUNT: rd_mux = count[unit_select_r];
            OFS_CAPTURED: rd_mux = captured[unit_select_r];
            OFS_UNIT_STATE: rd_mux[2:0] = state[unit_select_r];
            OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_r;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
                // read-only offsets refuse writes too
                pslverr_r <= !known || (pwrite && (paddr == OFS_PRESENT_COUNT ||
                             paddr == OFS_UNIT_STATE));
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r && pready_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_select_r <= 1'b0;
        end else if (wr_go && paddr == OFS_UNIT_SELECT) begin
            unit_select_r <= pwdata[0];
        end
    end

    // configuration per unit; a change applies on the next edge
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_cfg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[u] <= '0;
                end else if (wr_go && unit_select_r == 1'(u)) begin
                    case (paddr)
                        OFS_CONTROL: cfg_r[u].enable <= pwdata[0];
                        OFS_INCREMENT: cfg_r[u].inc <= wsel;
                        OFS_START_TRIGGER: begin
                            cfg_r[u].trg <= wsel;
                            if (wsel.src != SRC_OFF) begin
                                cfg_r[u].clr.src <= SRC_OFF;
                            end
                        end
                        OFS_CLEAR: begin
                            cfg_r[u].clr <= wsel;
                            if (wsel.src != SRC_OFF) begin
                                cfg_r[u].trg.src <= SRC_OFF;
                            end
                        end
                        OFS_DELAY: cfg_r[u].delay <= pwdata;
                        OFS_DURATION: cfg_r[u].duration <= pwdata;
                        default: cfg_r[u] <= cfg_r[u];
                    endcase
                end
            end
        end
    endgenerate

    // sticky events; a set in the clearing cycle survives
    assign irq_events = {ovf_p, finish_p, begin_p};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= RST_IRQ;
        end else if (wr_go && paddr == OFS_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~pwdata[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status_r <= irq_status_r | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= RST_IRQ;
        end else if (wr_go && paddr == OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end
endmodule
`default_nettype wire

// ---- hw/dect_pkg.sv ----
// shared constants, types and helpers for the dual event counter timer
package dect_pkg;

    localparam int SRC_W = 5;
    localparam int ACT_W = 3;
    localparam int CNT_W = 32;
    localparam int NUM_UNITS = 2;
    localparam int NUM_SRC = 19;
    localparam int NUM_LINES = 4;
    localparam int SYNC_STAGES = 3;

    // source codes, shared by increment, start trigger and clear selectors
    localparam logic [SRC_W-1:0] SRC_OFF = 5'h00;
    localparam logic [SRC_W-1:0] SRC_TICK = 5'h01;
    localparam logic [SRC_W-1:0] SRC_LINE0 = 5'h02;
    localparam logic [SRC_W-1:0] SRC_USER0 = 5'h06;
    localparam logic [SRC_W-1:0] SRC_BEGIN0 = 5'h0A;
    localparam logic [SRC_W-1:0] SRC_FINISH0 = 5'h0C;
    localparam logic [SRC_W-1:0] SRC_LOGIC0 = 5'h0E;
    localparam logic [SRC_W-1:0] SRC_EXP_BEGIN = 5'h10;
    localparam logic [SRC_W-1:0] SRC_EXP_FINISH = 5'h11;
    localparam logic [SRC_W-1:0] SRC_FRAME_WAIT = 5'h12;

    typedef enum logic [ACT_W-1:0] {
        ACT_LEVEL_LOW = 3'h0,
        ACT_LEVEL_HIGH = 3'h1,
        ACT_FALL = 3'h2,
        ACT_RISE = 3'h3,
        ACT_ANY = 3'h4
    } dect_act_t;

    // gray along idle -> wait -> active -> completed
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_TRIGGER_WAIT = 3'h1,
        ST_ACTIVE = 3'h3,
        ST_COMPLETED = 3'h2,
        ST_OVERFLOW = 3'h6
    } dect_state_t;

    typedef struct packed {
        logic [ACT_W-1:0] act;
        logic [SRC_W-1:0] src;
    } dect_sel_t;

    typedef struct packed {
        logic enable;
        dect_sel_t inc;
        dect_sel_t trg;
        dect_sel_t clr;
        logic [CNT_W-1:0] delay;
        logic [CNT_W-1:0] duration;
    } dect_cfg_t;

    // register byte offsets
    localparam logic [11:0] OFS_UNIT_SELECT = 12'h000;
    localparam logic [11:0] OFS_CONTROL = 12'h004;
    localparam logic [11:0] OFS_INCREMENT = 12'h008;
    localparam logic [11:0] OFS_START_TRIGGER = 12'h00C;
    localparam logic [11:0] OFS_CLEAR = 12'h010;
    localparam logic [11:0] OFS_DELAY = 12'h014;
    localparam logic [11:0] OFS_DURATION = 12'h018;
    localparam logic [11:0] OFS_PRESENT_COUNT = 12'h01C;
    localparam logic [11:0] OFS_CAPTURED = 12'h020;
    localparam logic [11:0] OFS_UNIT_STATE = 12'h024;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h028;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h02C;

    // field positions
    localparam int SEL_SRC_LSB = 0;
    localparam int SEL_ACT_LSB = 8;
    localparam int IRQ_BEGIN_LSB = 0;
    localparam int IRQ_FINISH_LSB = 2;
    localparam int IRQ_OVF_LSB = 4;
    localparam int IRQ_W = 6;

    // reset values
    localparam logic [CNT_W-1:0] RST_COUNT = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 6'h00;

    function automatic logic qualify(input logic cur, input logic prev,
                                     input logic [ACT_W-1:0] act);
        logic hit;
        hit = 1'b0;
        case (act)
            ACT_LEVEL_LOW: hit = !cur;
            ACT_LEVEL_HIGH: hit = cur;
            ACT_FALL: hit = prev && !cur;
            ACT_RISE: hit = !prev && cur;
            ACT_ANY: hit = prev ^ cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// ---- hw/dect_line_sync.sv ----
// three-stage synchroniser for the external line inputs
`timescale 1ns/1ps
`default_nettype none
module dect_line_sync
    import dect_pkg::*;
#(
    parameter int WIDTH = NUM_LINES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // lines
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_out[i] <= 1'b0;
                end else if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- hw/dect_unit.sv ----
// one event counter with start trigger, clear and capture
`timescale 1ns/1ps
`default_nettype none
module dect_unit
    import dect_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration and sources
    input wire dect_cfg_t cfg,
    input wire logic [NUM_SRC-1:0] src_cur,
    input wire logic [NUM_SRC-1:0] src_prev,
    // software write of the captured value
    input wire logic cap_wr,
    input wire logic [CNT_W-1:0] cap_wdata,
    // status
    output logic [CNT_W-1:0] count_r,
    output logic [CNT_W-1:0] captured_r,
    output dect_state_t state_r,
    output logic begin_pulse_r,
    output logic finish_pulse_r,
    output logic overflow_pulse_r
);
    logic inc_hit;
    logic trg_hit;
    logic clr_hit;
    logic step;
    logic [CNT_W-1:0] count_nxt;
    logic live;
    logic trg_off;

    // off or unknown codes disconnect the input
    function automatic logic pick(input dect_sel_t sel, input logic [NUM_SRC-1:0] cur,
                                  input logic [NUM_SRC-1:0] prev);
        logic hit;
        hit = 1'b0;
        if (sel.src != SRC_OFF && sel.src <= SRC_FRAME_WAIT) begin
            hit = qualify(cur[sel.src], prev[sel.src], sel.act);
        end
        return hit;
    endfunction

    always_comb begin
        inc_hit = pick(cfg.inc, src_cur, src_prev);
        trg_hit = pick(cfg.trg, src_cur, src_prev);
        clr_hit = pick(cfg.clr, src_cur, src_prev);
        live = cfg.enable && state_r != ST_IDLE;
        trg_off = cfg.trg.src == SRC_OFF || cfg.trg.src > SRC_FRAME_WAIT;
        step = cfg.enable && state_r == ST_ACTIVE && inc_hit && !clr_hit;
        count_nxt = count_r + 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            count_r <= RST_COUNT;
        end else if (!cfg.enable) begin
            state_r <= ST_IDLE;
            count_r <= RST_COUNT;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    count_r <= RST_COUNT;
                    state_r <= trg_off ? ST_ACTIVE : ST_TRIGGER_WAIT;
                end
                ST_TRIGGER_WAIT: begin
                    // trigger begins count; a dropped trigger source ends the wait
                    if (trg_hit || trg_off) begin
                        state_r <= ST_ACTIVE;
                        count_r <= RST_COUNT;
                    end
                end
                ST_ACTIVE: begin
                    if (clr_hit) begin
                        count_r <= RST_COUNT;
                    end else if (step) begin
                        if (&count_r) begin
                            state_r <= ST_OVERFLOW;
                        end else begin
                            count_r <= count_nxt;
                            if (count_nxt == cfg.duration) begin
                                state_r <= ST_COMPLETED;
                            end
                        end
                    end
                end
                ST_COMPLETED, ST_OVERFLOW: begin
                    // re-arm on a fresh trigger or clear
                    if (clr_hit || trg_hit) begin
                        state_r <= ST_ACTIVE;
                        count_r <= RST_COUNT;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    count_r <= RST_COUNT;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_r <= RST_COUNT;
        end else if (live && clr_hit) begin
            captured_r <= count_r;
        end else if (cap_wr) begin
            captured_r <= cap_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            begin_pulse_r <= 1'b0;
            finish_pulse_r <= 1'b0;
            overflow_pulse_r <= 1'b0;
        end else begin
            begin_pulse_r <= step && !(&count_r) && count_nxt == cfg.delay;
            finish_pulse_r <= step && !(&count_r) && count_nxt == cfg.duration;
            overflow_pulse_r <= step && (&count_r);
        end
    end
endmodule
`default_nettype wire

// ---- tb/dect_props.sv ----
// assertion checker for the dual event counter timer top ports
`timescale 1ns/1ps
`default_nettype none
module dect_props
    import dect_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // unit events and interrupt
    input wire logic [NUM_UNITS-1:0] unit_begin_pulse,
    input wire logic [NUM_UNITS-1:0] unit_finish_pulse,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    assign setup = psel && !penable;
    chk_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_has_cause: assert property (pready |-> $past(setup))
        else $error("pready without setup");
    chk_err_ro_write: assert property (setup && pwrite
        && (paddr == OFS_PRESENT_COUNT || paddr == OFS_UNIT_STATE) |=> pslverr)
        else $error("write to read-only place not refused");
    chk_err_unmapped: assert property (setup && paddr > OFS_IRQ_MASK
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_mapped_read_ok: assert property (setup && !pwrite
        && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped read refused");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    chk_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq
        && unit_begin_pulse == 2'b00 && unit_finish_pulse == 2'b00)
        else $error("outputs active after reset");
    chk_begin_single: assert property
        ((unit_begin_pulse & $past(unit_begin_pulse)) == 2'b00)
        else $error("begin pulse longer than a cycle");
    chk_finish_single: assert property
        ((unit_finish_pulse & $past(unit_finish_pulse)) == 2'b00)
        else $error("finish pulse longer than a cycle");
endmodule
bind dect_top dect_props dect_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .unit_begin_pulse,
    .unit_finish_pulse, .irq);
`default_nettype wire

// ---- tb/dect_src_model.sv ----
// event source model: scaled tick and a repeating exposure sequence
`timescale 1ns/1ps
`default_nettype none
module dect_src_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic tick_en,
    input wire logic exp_en,
    // acquisition events
    output logic microsecond_tick,
    output logic exposure_begin_event,
    output logic exposure_finish_event,
    output logic frame_trigger_pending
);
    logic [2:0] div_r;
    logic [3:0] ph_r;
    // tick every 8 cycles, shortened to keep runs brief
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 3'h0;
        end else begin
            div_r <= tick_en ? div_r + 3'h1 : 3'h0;
        end
    end
    assign microsecond_tick = tick_en && div_r == 3'h7;
    // pending, then exposure begin, then finish
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 4'h0;
        end else begin
            ph_r <= exp_en ? ph_r + 4'h1 : 4'h0;
        end
    end
    assign frame_trigger_pending = exp_en && ph_r < 4'h4;
    assign exposure_begin_event = exp_en && ph_r == 4'h4;
    assign exposure_finish_event = exp_en && ph_r == 4'hA;
endmodule
`default_nettype wire

// ---- tb/dect_top_tb_top.sv ----
// self-checking bench for the dual event counter timer
`timescale 1ns/1ps
`default_nettype none
module dect_top_tb_top
    import dect_pkg::*;
;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} dect_exp_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, irq, microsecond_tick, exposure_begin_event;
    logic exposure_finish_event, frame_trigger_pending, tick_en = 1'b0, exp_en = 1'b0;
    logic [1:0] unit_begin_pulse, unit_finish_pulse;
    logic [4:0] pv = 5'h00, rnd_r = 5'h00;
    int bad_count = 0, checked = 0, seed = 32'h0000_fd92, n, nb = 0;
    dect_exp_t q[$], e;
    logic [4:0] t_src [7] = '{6, 6, 6, 6, 6, 2, 0};
    logic [2:0] t_act [7] = '{0, 1, 2, 3, 4, 3, 3};
    logic [31:0] t_exp [7] = '{3, 3, 1, 1, 2, 1, 0};
    always #5 pclk = ~pclk;
    // unused source bits carry random noise
    always @(posedge pclk) rnd_r <= 5'($random(seed));
    dect_src_model dect_src_model_inst (.pclk, .presetn, .tick_en, .exp_en,
        .microsecond_tick, .exposure_begin_event, .exposure_finish_event,
        .frame_trigger_pending);
    dect_top dect_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .microsecond_tick,
        .line_in({rnd_r[4:2], pv[2]}), .soft_output_line({rnd_r[1:0], pv[1:0]}),
        .logic_unit_output(pv[4:3]), .exposure_begin_event, .exposure_finish_event,
        .frame_trigger_pending, .unit_begin_pulse, .unit_finish_pulse, .irq);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hFFFF_FFFF, input logic er = 1'b0);
        q.push_back('{d, m, er});
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    function automatic logic [31:0] f(input logic [2:0] a, input logic [4:0] s);
        return {21'h00_0000, a, 3'h0, s};
    endfunction
    // toggles one source away from its idle level for w cycles
    task automatic pulse(input int b, input int w);
        pv[b] <= ~pv[b];
        repeat (w) @(posedge pclk);
        pv[b] <= ~pv[b];
        repeat (8) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = q.pop_front();
            chk(prdata & e.m, e.d & e.m);
            chk({31'h0000_0000, pslverr}, {31'h0000_0000, e.e});
        end
    end
    task automatic test_done();
        $display("counts: checked=%0d bad=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_UNIT_STATE, 32'(ST_IDLE));
        rd(OFS_IRQ_STATUS, 32'h0000_0000);
        xfer(1'b1, OFS_PRESENT_COUNT, 32'h0000_0005);
        rd(OFS_PRESENT_COUNT, 32'h0000_0000);
        rd(12'h030, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        $display("test reset done");
        xfer(1'b1, OFS_INCREMENT, f(ACT_RISE, SRC_TICK));
        xfer(1'b1, OFS_DELAY, 32'h0000_0002);
        xfer(1'b1, OFS_DURATION, 32'h0000_0003);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0001);
        tick_en <= 1'b1;
        exp_en <= 1'b1;
        n = 0;
        while (unit_finish_pulse[0] !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
            if (unit_begin_pulse[0] === 1'b1) nb++;
        end
        tick_en <= 1'b0;
        chk(n < 300, 1'b1);
        chk(nb, 32'h0000_0001);
        rd(OFS_UNIT_STATE, 32'(ST_COMPLETED));
        rd(OFS_PRESENT_COUNT, 32'h0000_0003);
        rd(OFS_IRQ_STATUS, 32'h0000_0005);
        chk(irq, 1'b0);
        xfer(1'b1, OFS_IRQ_MASK, 32'h0000_003F);
        // irq is registered behind the mask, so look one edge later
        @(posedge pclk);
        chk(irq, 1'b1);
        xfer(1'b1, OFS_IRQ_STATUS, 32'h0000_0005);
        xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        rd(OFS_IRQ_STATUS, 32'h0000_0000);
        chk(irq, 1'b0);
        $display("test tick count done");
        xfer(1'b1, OFS_UNIT_SELECT, 32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, OFS_CONTROL, 32'h0000_0000);
            pv[0] <= (t_act[i] == 3'(ACT_LEVEL_LOW));
            xfer(1'b1, OFS_INCREMENT, f(t_act[i], t_src[i]));
            xfer(1'b1, OFS_CONTROL, 32'h0000_0001);
            repeat (3) @(posedge pclk);
            pulse((t_src[i] == SRC_LINE0) ? 2 : 0, 3);
            rd(OFS_PRESENT_COUNT, t_exp[i]);
        end
        $display("test activation done");
        xfer(1'b1, OFS_UNIT_SELECT, 32'h0000_0000);
        xfer(1'b1, OFS_CONTROL, 32'h0000_0000);
        xfer(1'b1, OFS_INCREMENT, f(ACT_RISE, 5'h07));
        xfer(1'b1, OFS_START_TRIGGER, f(ACT_RISE, SRC_LOGIC0));
        xfer(1'b1, OFS_CONTROL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        rd(OFS_UNIT_STATE, 32'(ST_TRIGGER_WAIT));
        pulse(1, 1);
        rd(OFS_PRESENT_COUNT, 32'h0000_0000);
        pulse(3, 1);
        rd(OFS_UNIT_STATE, 32'(ST_ACTIVE));
        for (int i = 0; i < 3; i++) pulse(1, 1);
        rd(OFS_UNIT_STATE, 32'(ST_COMPLETED));
        xfer(1'b1, OFS_CLEAR, f(ACT_RISE, 5'h0F));
        rd(OFS_START_TRIGGER, 32'h0000_0000, 32'h0000_001F);
        pulse(4, 1);
        rd(OFS_CAPTURED, 32'h0000_0003);
        rd(OFS_PRESENT_COUNT, 32'h0000_0000);
        rd(OFS_UNIT_STATE, 32'(ST_ACTIVE));
        r = $random(seed);
        xfer(1'b1, OFS_CAPTURED, r);
        rd(OFS_CAPTURED, r);
        xfer(1'b1, OFS_UNIT_SELECT, 32'h0000_0001);
        rd(OFS_INCREMENT, f(ACT_RISE, SRC_OFF));
        $display("test trigger clear done");
        test_done();
    end
endmodule
`default_nettype wire
